// ### verilog/slm_strap_latch.sv
`timescale 1ns/100ps
module slm_strap_latch (
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  input  wire logic                i_power_good,
  input  wire slm_pkg::slm_strap_s i_strap,
  input  wire logic                i_sw_debug_enable,
  input  wire logic                i_sdram_write,
  input  wire logic                i_sdram_read,
  input  wire slm_pkg::slm_src_s   i_rank_contrib,
  input  wire slm_pkg::slm_src_s   i_read_initiator,
  output logic [1:0]               o_boot_width,
  output logic                     o_boot_on_sdram_bus,
  output logic                     o_cfg3,
  output logic                     o_debug_mode_disabled,
  output logic                     o_debug_mode_enabled,
  output logic                     o_strap_sample_window,
  output logic                     o_dma_source_flag,
  output logic                     o_pci_source_flag,
  output logic                     o_cpu_source_flag
);
  function automatic slm_pkg::slm_width_e width_dec(input slm_pkg::slm_strap_s s);
    if (s.width_hi) begin
      width_dec = slm_pkg::SLM_W32; // RULE11
    end else if (s.width_lo) begin
      width_dec = slm_pkg::SLM_W16;
    end else begin
      width_dec = slm_pkg::SLM_W8;
    end
  endfunction

  logic               pg_reg, pg_next;
  slm_pkg::slm_strap_s strap_reg, strap_next;
  logic [1:0]         width_reg, width_next;
  logic               dbg_en_reg, dbg_en_next;
  logic               win_reg, win_next;
  slm_pkg::slm_src_s  src_reg, src_next;
  logic               pg_rise;

  // strap capture on power-good rising edge
  always_comb begin
    pg_next    = i_power_good;
    pg_rise    = i_power_good & ~pg_reg;
    strap_next = strap_reg;
    width_next = width_reg;
    win_next   = ~i_power_good;
    if (pg_rise) begin
      strap_next = i_strap; // RULE5
      width_next = width_dec(i_strap); // RULE8
    end
  end

  // software debug enable gated by latched disable
  always_comb begin
    dbg_en_next = dbg_en_reg;
    if (pg_rise) begin
      dbg_en_next = 1'b0;
    end else if (!strap_reg.debug_dis) begin
      dbg_en_next = i_sw_debug_enable; // RULE7
    end else begin
      dbg_en_next = 1'b0; // RULE6
    end
  end

  // source mask
  always_comb begin
    src_next = '0;
    if (i_sdram_write) begin
      src_next = i_rank_contrib; // RULE4
    end else if (i_sdram_read) begin
      src_next = i_read_initiator;
    end
  end

  // strap group registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pg_reg    <= 1'h0;
      strap_reg <= slm_pkg::STRAP_RST; // RULE12
      width_reg <= slm_pkg::SLM_W8;
      win_reg   <= 1'h1;
    end else begin
      pg_reg    <= pg_next;
      strap_reg <= strap_next; // RULE9
      width_reg <= width_next;
      win_reg   <= win_next;
    end
  end

  // debug group registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      dbg_en_reg <= 1'h0;
    end else begin
      dbg_en_reg <= dbg_en_next;
    end
  end

  // source group registers
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      src_reg <= '0;
    end else begin
      src_reg <= src_next;
    end
  end

  always_comb begin
    o_boot_width          = width_reg;
    o_boot_on_sdram_bus   = strap_reg.bus_sel; // RULE10
    o_cfg3                = strap_reg.cfg3;
    o_debug_mode_disabled = strap_reg.debug_dis;
    o_debug_mode_enabled  = dbg_en_reg;
    o_strap_sample_window = win_reg;
    o_dma_source_flag     = src_reg.dma; // RULE1
    o_pci_source_flag     = src_reg.pci; // RULE2
    o_cpu_source_flag     = src_reg.cpu; // RULE3
  end

  // per-initiator views indexed by the package source positions
  logic [slm_pkg::SRC_W-1:0] flag_vec;
  logic [slm_pkg::SRC_W-1:0] contrib_vec;
  logic [slm_pkg::SRC_W-1:0] init_vec;

  always_comb begin
    flag_vec                      = '0;
    contrib_vec                   = '0;
    init_vec                      = '0;
    flag_vec[slm_pkg::SRC_DMA]    = o_dma_source_flag;
    flag_vec[slm_pkg::SRC_PCI]    = o_pci_source_flag;
    flag_vec[slm_pkg::SRC_CPU]    = o_cpu_source_flag;
    contrib_vec[slm_pkg::SRC_DMA] = i_rank_contrib.dma;
    contrib_vec[slm_pkg::SRC_PCI] = i_rank_contrib.pci;
    contrib_vec[slm_pkg::SRC_CPU] = i_rank_contrib.cpu;
    init_vec[slm_pkg::SRC_DMA]    = i_read_initiator.dma;
    init_vec[slm_pkg::SRC_PCI]    = i_read_initiator.pci;
    init_vec[slm_pkg::SRC_CPU]    = i_read_initiator.cpu;
  end

  // source flag checks
  a_dma_flag_write: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE1
    i_sdram_write |=> o_dma_source_flag == $past(i_rank_contrib.dma))
    else $error("dma flag mismatch on write");
  a_dma_flag_read: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE1
    (i_sdram_read && !i_sdram_write) |=> o_dma_source_flag == $past(i_read_initiator.dma))
    else $error("dma flag mismatch on read");
  a_pci_flag_write: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE2
    i_sdram_write |=> o_pci_source_flag == $past(i_rank_contrib.pci))
    else $error("pci flag mismatch on write");
  a_pci_flag_read: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE2
    (i_sdram_read && !i_sdram_write) |=> o_pci_source_flag == $past(i_read_initiator.pci))
    else $error("pci flag mismatch on read");
  a_cpu_flag_write: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE3
    i_sdram_write |=> o_cpu_source_flag == $past(i_rank_contrib.cpu))
    else $error("cpu flag mismatch on write");
  a_cpu_flag_read: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE3
    (i_sdram_read && !i_sdram_write) |=> o_cpu_source_flag == $past(i_read_initiator.cpu))
    else $error("cpu flag mismatch on read");
  a_merge_mask: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE4
    i_sdram_write |=> {o_dma_source_flag, o_pci_source_flag, o_cpu_source_flag}
    == $past(i_rank_contrib))
    else $error("merged write mask mismatch");
  a_idle_mask_zero: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE4
    !(i_sdram_write || i_sdram_read) |=> !(o_dma_source_flag || o_pci_source_flag
    || o_cpu_source_flag))
    else $error("mask active while idle");

  for (genvar g = 0; g < slm_pkg::SRC_W; g++) begin : g_flag_chk
    a_flag_bit: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE4
      (i_sdram_write || i_sdram_read) |=>
      flag_vec[g] == $past(i_sdram_write ? contrib_vec[g] : init_vec[g]))
      else $error("source flag bit mismatch");
  end

  // strap capture checks
  a_strap_capture: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE10
    $rose(i_power_good) |=> o_boot_on_sdram_bus == $past(i_strap.bus_sel))
    else $error("bus select not captured");
  a_cfg3_capture: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE5
    (i_power_good && !pg_reg) |=> o_cfg3 == $past(i_strap.cfg3))
    else $error("fourth strap not captured");
  a_dis_capture: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE6
    (i_power_good && !pg_reg) |=> o_debug_mode_disabled == $past(i_strap.debug_dis))
    else $error("debug disable strap not captured");
  a_window_tracks: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE9
    1'h1 |=> o_strap_sample_window == !$past(i_power_good))
    else $error("sample window wrong");
  a_strap_hold: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE9
    !(i_power_good && !pg_reg) |=> $stable(o_boot_on_sdram_bus)
    && $stable(o_debug_mode_disabled) && $stable(o_cfg3)
    && $stable(o_boot_width))
    else $error("strap changed without power-good edge");

  // boot width checks
  a_width_32: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE11
    (i_power_good && !pg_reg && i_strap.width_hi) |=> o_boot_width == slm_pkg::SLM_W32)
    else $error("width not 32 bit");
  a_width_16: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE8
    (i_power_good && !pg_reg && !i_strap.width_hi && i_strap.width_lo)
    |=> o_boot_width == slm_pkg::SLM_W16)
    else $error("width not 16 bit");
  a_width_8: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE8
    (i_power_good && !pg_reg && !i_strap.width_hi && !i_strap.width_lo)
    |=> o_boot_width == slm_pkg::SLM_W8)
    else $error("width not 8 bit");

  // debug mode checks
  a_debug_locked: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE6
    o_debug_mode_disabled |-> !o_debug_mode_enabled)
    else $error("debug enabled while disabled");
  a_debug_allowed: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE7
    (!o_debug_mode_disabled && i_sw_debug_enable && !(i_power_good && !pg_reg))
    |=> o_debug_mode_enabled)
    else $error("debug enable refused");
  a_debug_follow: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE7
    !i_sw_debug_enable |=> !o_debug_mode_enabled)
    else $error("debug enabled without request");
  a_debug_rise_clear: assert property (@(posedge i_core_clk) disable iff (i_rst) // RULE6
    (i_power_good && !pg_reg) |=> !o_debug_mode_enabled)
    else $error("debug not cleared on power-good edge");

  // reset checks
  a_reset_zero: assert property (@(posedge i_core_clk) // RULE12
    i_rst |=> (o_boot_width == slm_pkg::SLM_W8 && !o_debug_mode_disabled
    && !o_boot_on_sdram_bus && !o_cfg3 && !o_debug_mode_enabled
    && o_strap_sample_window
    && !(o_dma_source_flag || o_pci_source_flag || o_cpu_source_flag)))
    else $error("straps not zero after reset");
endmodule // slm_strap_latch

// ### verilog/slm_pkg.sv
// Overview of operation
// [RULE1] dma source flag high when dma wrote into rank or reads sdram
// [RULE2] pci source flag high when pci wrote into rank or reads sdram
// [RULE3] cpu source flag high when cpu wrote into rank or reads sdram
// [RULE4] flags form per-initiator mask; several may be high on merged writes
// [RULE5] five configuration straps latched at power-good assertion, held until next
// [RULE6] debug-disable strap high at power-good blocks software debug enable
// [RULE7] debug-disable strap low lets software enable debug mode
// [RULE8] two lowest latched straps select 8, 16 or 32 bit boot width
// [RULE9] strap pins carry other functions afterwards; later levels ignored
// [RULE10] third strap low uses general-purpose bus, high uses sdram bus
// [RULE11] hi=0 lo=0 8 bits; hi=0 lo=1 16 bits; hi=1 32 bits
// [RULE12] latched straps read zero before first power-good assertion
package slm_pkg;
  localparam int SRC_DMA = 0;
  localparam int SRC_PCI = 1;
  localparam int SRC_CPU = 2;
  localparam int SRC_W   = 3;

  typedef enum logic [1:0] {
    SLM_W8  = 2'h0,
    SLM_W16 = 2'h1,
    SLM_W32 = 2'h2
  } slm_width_e;

  typedef struct packed {
    logic debug_dis;
    logic cfg3;
    logic bus_sel;
    logic width_hi;
    logic width_lo;
  } slm_strap_s;

  localparam slm_strap_s STRAP_RST = '{default: 1'b0};

  typedef struct packed {
    logic dma;
    logic pci;
    logic cpu;
  } slm_src_s;
endpackage

// ### verification/slm_board_model.sv
`timescale 1ns/100ps
module slm_board_model (
  input  wire logic                i_present,
  input  wire slm_pkg::slm_strap_s i_level,
  output slm_pkg::slm_strap_s      o_strap
);
  // pull levels shown only in the sample window, pins reused and toggled after
  assign o_strap = i_present ? i_level : ~i_level;
endmodule // slm_board_model

// ### verification/slm_strap_latch_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module slm_strap_latch_tb;
  logic                clk = 1'b0, rst = 1'b1, pg = 1'b0, sw = 1'b0, wr = 1'b0, rd = 1'b0;
  slm_pkg::slm_strap_s lvl = 5'h1F;
  slm_pkg::slm_strap_s pin;
  slm_pkg::slm_src_s   contrib = 3'h0, init = 3'h0;
  logic [1:0]          width;
  logic                bus, cfg3, ddis, den, win, fd, fp, fc;
  int                  bad_count = 0, samples_checked = 0;
  always #50 clk = ~clk;
  slm_board_model board (.i_present(win), .i_level(lvl), .o_strap(pin));
  slm_strap_latch dut (.i_core_clk(clk), .i_rst(rst), .i_power_good(pg), .i_strap(pin),
    .i_sw_debug_enable(sw), .i_sdram_write(wr), .i_sdram_read(rd),
    .i_rank_contrib(contrib), .i_read_initiator(init), .o_boot_width(width),
    .o_boot_on_sdram_bus(bus), .o_cfg3(cfg3), .o_debug_mode_disabled(ddis),
    .o_debug_mode_enabled(den), .o_strap_sample_window(win), .o_dma_source_flag(fd),
    .o_pci_source_flag(fp), .o_cpu_source_flag(fc));
  task conclude;
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task latch_check(input logic [4:0] s);
    logic [1:0] w;
    w = s[1] ? 2'h2 : {1'b0, s[0]};
    @(negedge clk) pg = 1'b0;
    lvl = s;
    repeat (2) @(negedge clk);
    pg = 1'b1;
    repeat (2) @(negedge clk);
    sw = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("width", w, width)
    `CHK("sdram_bus", s[2], bus)
    `CHK("cfg3", s[3], cfg3)
    `CHK("debug_dis", s[4], ddis)
    `CHK("debug_en", ~s[4], den)
    `CHK("window", 1'h0, win)
    sw = 1'b0;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("width_rst", 2'h0, width)
    `CHK("straps_rst", 3'h0, {bus, cfg3, ddis})
    `CHK("outputs_rst", 5'h10, {win, den, fd, fp, fc})
    for (int i = 0; i < 32; i++) latch_check(5'(i));
    for (int m = 0; m < 8; m++) begin
      wr = 1'b1;
      rd = (m > 3);
      contrib = 3'(m);
      init = ~3'(m);
      @(negedge clk);
      `CHK("write_mask", 3'(m), {fd, fp, fc})
      wr = 1'b0;
      rd = 1'b1;
      contrib = ~3'(m);
      init = 3'(m);
      @(negedge clk);
      `CHK("read_mask", 3'(m), {fd, fp, fc})
    end
    rd = 1'h0;
    @(negedge clk);
    `CHK("idle_mask", 3'h0, {fd, fp, fc})
    rst = 1'h1;
    repeat (2) @(negedge clk);
    `CHK("straps_mid_rst", 3'h0, {bus, cfg3, ddis})
    rst = 1'h0;
    repeat (2) @(negedge clk);
    `CHK("relatch_width", slm_pkg::SLM_W32, width)
    `CHK("relatch_dis", 1'h1, ddis)
    conclude();
  end
  initial begin
    #(100 * 3000);
    bad_count++;
    conclude();
  end
endmodule // slm_strap_latch_tb
